// ==== core/sio_device.sv ====
// serial port device end: shift paths, word buffers, timing generators, tdm slots
// assumes the peer keeps its side of the link and software uses the plain port
//
// The placing of the registers and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
module sio_device #(
  parameter int HALF_CYC = sio_pkg::HALF_BIT_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // link
  sio_link_if.device link,
  // register port
  input wire logic [2:0] addr,
  input wire logic [sio_pkg::WORD_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [sio_pkg::WORD_W-1:0] rdata,
  // interrupt
  output logic irq
);
  import sio_pkg::*;

  logic [NPIN-1:0] s_lvl;
  logic [NPIN-1:0] s_rise;
  logic [NPIN-1:0] s_fall;
  logic [CTRL_W-1:0] ctrl;
  logic [TDM_W-1:0] tdm;
  logic [WORD_W-1:0] rx_buf, isr, tx_buf, osr, addr_buf, asr;
  logic rx_full, tx_empty, tx_bit, addr_bit;
  logic [1:0] int_st, int_mask;
  logic [7:0] div_cnt;
  logic gen_clk, gen_ld, gen_frame;
  logic [3:0] bit_cnt, frame_cnt;
  logic [SLOT_W-1:0] slot_cnt;
  logic gen_tick, gen_rise, resync, gen_ld_fall, frame_last, gen_frame_fall;
  logic rx_rise, rx_ldf, tx_rise, tx_ldf, frame_fall, master, mp, my_slot, en_n;
  logic [WORD_W-1:0] tx_src, a_src;

  // every link input is synchronised before use
  sio_sync #(.W(NPIN)) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d(link.level),
    .lvl(s_lvl),
    .rise(s_rise),
    .fall(s_fall)
  );

  // internal timing events
  assign master = tdm[T_FRAME_MASTER];
  assign mp = tdm[T_MP_MODE];
  assign gen_tick = div_cnt == 8'(HALF_CYC - 1);
  assign gen_rise = gen_tick & ~gen_clk;
  assign resync = ~master & s_fall[FRAME_MARKER_LINE];
  assign gen_ld_fall = gen_ld & (resync | (gen_rise & bit_cnt == 4'hF));
  assign frame_last = tdm[T_FRAME_DIVIDER] ? (frame_cnt == FRAME_DIV16_LAST) : (frame_cnt == FRAME_DIV8_LAST);
  assign gen_frame_fall = gen_ld_fall & frame_last & gen_frame;

  // active or passive edge selection per path
  assign rx_rise = ctrl[C_RX_TIMING_DIR] ? gen_rise : s_rise[RX_BIT_TIMING];
  assign rx_ldf = ctrl[C_RX_LOAD_DIR] ? gen_ld_fall : s_fall[RX_WORD_LOAD];
  assign tx_rise = ctrl[C_TX_TIMING_DIR] ? gen_rise : s_rise[TX_BIT_TIMING];
  assign tx_ldf = ctrl[C_TX_LOAD_DIR] ? gen_ld_fall : s_fall[TX_WORD_LOAD];
  assign frame_fall = master ? gen_frame_fall : s_fall[FRAME_MARKER_LINE];

  // slot ownership; the frame master always owns slot 0
  assign my_slot = slot_cnt == (master ? '0 : tdm[T_SLOT_LSB +: SLOT_W]);
  assign en_n = mp ? ~my_slot : s_lvl[TX_SLOT_ENABLE_N];
  assign tx_src = tx_ldf ? tx_buf : osr;
  assign a_src = tx_ldf ? addr_buf : asr;

  // bit clock divider
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      div_cnt <= '0;
      gen_clk <= 1'b0;
    end
    else if (gen_tick)
    begin
      div_cnt <= '0;
      gen_clk <= ~gen_clk;
    end
    else
      div_cnt <= div_cnt + 8'h01;
  end

  // word load generator, low for the first bit of each 16
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bit_cnt <= 4'h1;
      gen_ld <= 1'b1;
    end
    else if (resync)
    begin
      bit_cnt <= 4'h0;
      gen_ld <= 1'b0;
    end
    else if (gen_rise)
    begin
      bit_cnt <= bit_cnt + 4'h1;
      gen_ld <= bit_cnt != 4'hF;
    end
  end

  // frame generator, low during slot 0 only
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      frame_cnt <= '0;
      gen_frame <= 1'b1;
    end
    else if (gen_ld_fall)
    begin
      frame_cnt <= frame_last ? 4'h0 : frame_cnt + 4'h1;
      gen_frame <= ~frame_last;
    end
  end

  // slot counter, restarted by each frame
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      slot_cnt <= '0;
    else if (frame_fall)
      slot_cnt <= '0;
    else if (tx_ldf)
      slot_cnt <= slot_cnt + SLOT_W'(1);
  end

  // receive shift and buffer
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      isr <= '0;
      rx_buf <= '0;
    end
    else
    begin
      if (rx_rise)
        isr <= shift_in(isr, s_lvl[SERIAL_RX_LINE], ctrl[C_MSB_FIRST]);
      // a load on a sampling rise keeps that rise's bit, the last one of the word
      if (rx_ldf)
        rx_buf <= rx_rise ? shift_in(isr, s_lvl[SERIAL_RX_LINE], ctrl[C_MSB_FIRST]) : isr;
    end
  end

  // transmit shift; a coinciding load feeds the first bit straight out
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      osr <= '0;
      asr <= '0;
      tx_bit <= 1'b1;
      addr_bit <= 1'b1;
    end
    else if (tx_rise)
    begin
      tx_bit <= pick_bit(tx_src, ctrl[C_MSB_FIRST]);
      osr <= shift_out(tx_src, ctrl[C_MSB_FIRST]);
      addr_bit <= ~pick_bit(a_src, ctrl[C_MSB_FIRST]);
      asr <= shift_out(a_src, ctrl[C_MSB_FIRST]);
    end
    else if (tx_ldf)
    begin
      osr <= tx_buf;
      asr <= addr_buf;
    end
  end

  // buffer flags; hardware set wins over software clear
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_full <= 1'b0;
      tx_empty <= 1'b1;
    end
    else
    begin
      if (rx_ldf)
        rx_full <= 1'b1;
      else if (rd && addr == A_DATA)
        rx_full <= 1'b0;
      if (tx_ldf)
        tx_empty <= 1'b1;
      else if (wr && addr == A_DATA)
        tx_empty <= 1'b0;
    end
  end

  // software registers
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl <= CTRL_RST;
      tdm <= TDM_RST;
      tx_buf <= '0;
      addr_buf <= '0;
      int_mask <= INT_RST;
    end
    else if (wr)
    begin
      case (addr)
        A_CTRL: ctrl <= wdata[CTRL_W-1:0];
        A_TDM: tdm <= wdata[TDM_W-1:0];
        A_DATA: tx_buf <= wdata;
        A_ADDR_TX: addr_buf <= wdata;
        A_INT_MASK: int_mask <= wdata[1:0];
        default: ;
      endcase
    end
  end

  // sticky events, write one to clear, set wins
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      int_st <= INT_RST;
      irq <= 1'b0;
    end
    else
    begin
      int_st <= (int_st & ~((wr && addr == A_INT_ST) ? wdata[1:0] : 2'b00)) | {tx_ldf, rx_ldf};
      irq <= |(int_st & int_mask);
    end
  end

  // read data, valid the cycle after the strobe
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rdata <= '0;
    else if (rd)
    begin
      case (addr)
        A_CTRL: rdata <= WORD_W'(ctrl);
        A_TDM: rdata <= WORD_W'(tdm);
        A_DATA: rdata <= rx_buf;
        A_ADDR_TX: rdata <= addr_buf;
        A_STATUS: rdata <= WORD_W'({tx_empty, rx_full});
        A_INT_ST: rdata <= WORD_W'(int_st);
        A_INT_MASK: rdata <= WORD_W'(int_mask);
        default: rdata <= '0;
      endcase
    end
    else
      rdata <= '0;
  end

  // pin drivers, all registered
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      link.dev_o <= '1;
      link.dev_oe <= '0;
    end
    else
    begin
      link.dev_o <= '1;
      link.dev_oe <= '0;
      link.dev_o[RX_BIT_TIMING] <= gen_clk;
      link.dev_oe[RX_BIT_TIMING] <= ctrl[C_RX_TIMING_DIR];
      link.dev_o[RX_WORD_LOAD] <= gen_ld;
      link.dev_oe[RX_WORD_LOAD] <= ctrl[C_RX_LOAD_DIR];
      link.dev_o[TX_BIT_TIMING] <= gen_clk;
      link.dev_oe[TX_BIT_TIMING] <= ctrl[C_TX_TIMING_DIR];
      link.dev_o[TX_WORD_LOAD] <= gen_ld;
      link.dev_oe[TX_WORD_LOAD] <= ctrl[C_TX_LOAD_DIR];
      link.dev_o[SERIAL_TX_LINE] <= tx_bit;
      link.dev_oe[SERIAL_TX_LINE] <= ~en_n;
      link.dev_o[TX_SLOT_ENABLE_N] <= ~my_slot;
      link.dev_oe[TX_SLOT_ENABLE_N] <= mp;
      link.dev_o[SERIAL_ADDR_LINE] <= addr_bit;
      link.dev_oe[SERIAL_ADDR_LINE] <= ~en_n;
      link.dev_o[FRAME_MARKER_LINE] <= gen_frame;
      link.dev_oe[FRAME_MARKER_LINE] <= master;
    end
  end
endmodule

// ==== common/sio_pkg.sv ====
// constants, pin indices and bit-order helpers for the serial port link
// assumes a 250 MHz core clock on both ends
package sio_pkg;
  localparam int WORD_W = 16;
  localparam int CLK_MHZ = 250;
  localparam int BIT_PERIOD_NS = 64;
  localparam int HALF_BIT_CYC = BIT_PERIOD_NS * CLK_MHZ / 2000;
  // pin indices into the link vectors
  localparam int NPIN = 9;
  localparam int RX_BIT_TIMING = 0;
  localparam int RX_WORD_LOAD = 1;
  localparam int TX_BIT_TIMING = 2;
  localparam int TX_WORD_LOAD = 3;
  localparam int SERIAL_TX_LINE = 4;
  localparam int TX_SLOT_ENABLE_N = 5;
  localparam int SERIAL_ADDR_LINE = 6;
  localparam int FRAME_MARKER_LINE = 7;
  localparam int SERIAL_RX_LINE = 8;
  localparam logic [NPIN-1:0] PIN_PULL = 9'h1FF;
  // register addresses
  localparam logic [2:0] A_CTRL = 3'h0;
  localparam logic [2:0] A_TDM = 3'h1;
  localparam logic [2:0] A_DATA = 3'h2;
  localparam logic [2:0] A_ADDR_TX = 3'h3;
  localparam logic [2:0] A_STATUS = 3'h4;
  localparam logic [2:0] A_INT_ST = 3'h5;
  localparam logic [2:0] A_INT_MASK = 3'h6;
  // control fields; the four direction bits 1 = active (device drives), C_MSB_FIRST 1 = msb first
  localparam int C_MSB_FIRST = 0;
  localparam int C_RX_TIMING_DIR = 1;
  localparam int C_RX_LOAD_DIR = 2;
  localparam int C_TX_TIMING_DIR = 3;
  localparam int C_TX_LOAD_DIR = 4;
  localparam int CTRL_W = 5;
  localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;
  // multiprocessor slot control fields
  localparam int T_MP_MODE = 0;
  localparam int T_FRAME_MASTER = 1;
  localparam int T_FRAME_DIVIDER = 2;
  localparam int T_SLOT_LSB = 4;
  localparam int SLOT_W = 3;
  localparam int TDM_W = 7;
  localparam logic [TDM_W-1:0] TDM_RST = 7'h00;
  localparam logic [3:0] FRAME_DIV8_LAST = 4'h7;
  localparam logic [3:0] FRAME_DIV16_LAST = 4'hF;
  // status and interrupt bits
  localparam int S_RX_FULL = 0;
  localparam int S_TX_EMPTY = 1;
  localparam logic [1:0] INT_RST = 2'h0;

  function automatic logic pick_bit(input logic [WORD_W-1:0] w, input logic msb);
    pick_bit = msb ? w[WORD_W-1] : w[0];
  endfunction

  function automatic logic [WORD_W-1:0] shift_out(input logic [WORD_W-1:0] w, input logic msb);
    shift_out = msb ? {w[WORD_W-2:0], 1'b0} : {1'b0, w[WORD_W-1:1]};
  endfunction

  function automatic logic [WORD_W-1:0] shift_in(input logic [WORD_W-1:0] w, input logic b,
                                                 input logic msb);
    shift_in = msb ? {w[WORD_W-2:0], b} : {b, w[WORD_W-1:1]};
  endfunction
endpackage

// ==== common/sio_link_if.sv ====
// link between the serial port device and its peer, one vector bit per pin
// assumes the bench joins both ends; undriven pins float high through pull-ups
`timescale 1ns/1ps
interface sio_link_if;
  import sio_pkg::*;
  logic [NPIN-1:0] dev_o;
  logic [NPIN-1:0] dev_oe;
  logic [NPIN-1:0] peer_o;
  logic [NPIN-1:0] peer_oe;
  logic [NPIN-1:0] level;

  // wire level resolved from the two enables, device first
  genvar i;
  generate
    for (i = 0; i < NPIN; i++)
    begin : g_pin
      assign level[i] = dev_oe[i] ? dev_o[i] : (peer_oe[i] ? peer_o[i] : PIN_PULL[i]);
    end
  endgenerate

  modport device (output dev_o, output dev_oe, input level);
  modport peer (output peer_o, output peer_oe, input level);
endinterface

// ==== core/sio_sync.sv ====
// two-stage synchroniser with edge detection for a group of pins
// assumes inputs are asynchronous to clk
`timescale 1ns/1ps
module sio_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // pins in, clean level and edges out
  input wire logic [W-1:0] d,
  output logic [W-1:0] lvl,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);
  logic [W-1:0] meta;
  logic [W-1:0] stab;
  logic [W-1:0] prev;

  // first stage feeds only the second
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta <= '1;
      stab <= '1;
      prev <= '1;
    end
    else
    begin
      meta <= d;
      stab <= meta;
      prev <= stab;
    end
  end

  assign lvl = stab;
  assign rise = stab & ~prev;
  assign fall = ~stab & prev;
endmodule

// ==== core/sio_peer.sv ====
// peer end: serial partner of the device, supplies passive timing when asked
// assumes configuration inputs are held steady while words flow
`timescale 1ns/1ps
module sio_peer #(
  parameter int HALF_CYC = sio_pkg::HALF_BIT_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // link
  sio_link_if.peer link,
  // configuration, drive inputs 1 = peer drives that pin; tdm_member 1 = peer releases slot enable and frame
  input wire logic drive_rx_timing,
  input wire logic drive_rx_load,
  input wire logic drive_tx_timing,
  input wire logic drive_tx_load,
  input wire logic msb_first,
  input wire logic tdm_member,
  input wire logic enable_device,
  // words to and from the device
  input wire logic [sio_pkg::WORD_W-1:0] send_word,
  input wire logic send_load,
  output logic [sio_pkg::WORD_W-1:0] recv_word,
  output logic recv_valid
);
  import sio_pkg::*;

  logic [NPIN-1:0] s_lvl, s_fall;
  logic [7:0] div_cnt;
  logic gen_clk, gen_ld, gen_tick, gen_ld_fall, out_bit;
  logic [3:0] bit_cnt;
  logic [WORD_W-1:0] send_buf, psr, prx;
  logic rbt_fall, rld_fall, tbt_fall, tld_fall;

  sio_sync #(.W(NPIN)) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d(link.level),
    .lvl(s_lvl),
    .rise(),
    .fall(s_fall)
  );

  // own timing when the device is passive; peer changes data on falls
  assign gen_tick = div_cnt == 8'(HALF_CYC - 1);
  assign gen_ld_fall = gen_tick & ~gen_clk & gen_ld & bit_cnt == 4'hF;
  assign rbt_fall = drive_rx_timing ? (gen_tick & gen_clk) : s_fall[RX_BIT_TIMING];
  assign rld_fall = drive_rx_load ? gen_ld_fall : s_fall[RX_WORD_LOAD];
  assign tbt_fall = drive_tx_timing ? (gen_tick & gen_clk) : s_fall[TX_BIT_TIMING];
  assign tld_fall = drive_tx_load ? gen_ld_fall : s_fall[TX_WORD_LOAD];

  // divider and word load generator
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      div_cnt <= '0;
      gen_clk <= 1'b0;
      bit_cnt <= 4'h1;
      gen_ld <= 1'b1;
    end
    else if (gen_tick)
    begin
      div_cnt <= '0;
      gen_clk <= ~gen_clk;
      if (!gen_clk)
      begin
        bit_cnt <= bit_cnt + 4'h1;
        gen_ld <= bit_cnt != 4'hF;
      end
    end
    else
      div_cnt <= div_cnt + 8'h01;
  end

  // send path toward the device receiver
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      send_buf <= '0;
      psr <= '0;
      out_bit <= 1'b1;
    end
    else
    begin
      if (send_load)
        send_buf <= send_word;
      if (rld_fall)
        psr <= send_buf;
      else if (rbt_fall)
      begin
        out_bit <= pick_bit(psr, msb_first);
        psr <= shift_out(psr, msb_first);
      end
    end
  end

  // receive path from the device transmitter, sampled mid-bit
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prx <= '0;
      recv_word <= '0;
      recv_valid <= 1'b0;
    end
    else
    begin
      recv_valid <= tld_fall;
      if (tld_fall)
        recv_word <= prx;
      if (tbt_fall)
        prx <= shift_in(prx, s_lvl[SERIAL_TX_LINE], msb_first);
    end
  end

  // pin drivers, all registered
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      link.peer_o <= '1;
      link.peer_oe <= '0;
    end
    else
    begin
      link.peer_o <= '1;
      link.peer_oe <= '0;
      link.peer_o[RX_BIT_TIMING] <= gen_clk;
      link.peer_oe[RX_BIT_TIMING] <= drive_rx_timing;
      link.peer_o[RX_WORD_LOAD] <= gen_ld;
      link.peer_oe[RX_WORD_LOAD] <= drive_rx_load;
      link.peer_o[TX_BIT_TIMING] <= gen_clk;
      link.peer_oe[TX_BIT_TIMING] <= drive_tx_timing;
      link.peer_o[TX_WORD_LOAD] <= gen_ld;
      link.peer_oe[TX_WORD_LOAD] <= drive_tx_load;
      link.peer_o[SERIAL_RX_LINE] <= out_bit;
      link.peer_oe[SERIAL_RX_LINE] <= 1'b1;
      link.peer_o[TX_SLOT_ENABLE_N] <= ~enable_device;
      link.peer_oe[TX_SLOT_ENABLE_N] <= ~tdm_member;
      link.peer_o[FRAME_MARKER_LINE] <= 1'b0;
      link.peer_oe[FRAME_MARKER_LINE] <= ~tdm_member;
    end
  end
endmodule

// ==== verif/sio_monitor.sv ====
// link checker: output gating, bit timing, word loads and frame rate
// assumes both ends run on clk and the bench wires in the link signals
`timescale 1ns/1ps
module sio_monitor #(
  parameter int HALF_CYC = sio_pkg::HALF_BIT_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // link signals
  input wire logic [sio_pkg::NPIN-1:0] dev_o,
  input wire logic [sio_pkg::NPIN-1:0] dev_oe,
  input wire logic [sio_pkg::NPIN-1:0] peer_o,
  input wire logic [sio_pkg::NPIN-1:0] peer_oe,
  input wire logic [sio_pkg::NPIN-1:0] level
);
  import sio_pkg::*;
  logic [NPIN-1:0] o_q;
  logic [NPIN-1:0] oe_q;
  logic [7:0] half_cnt;
  logic [7:0] ld_cnt;
  logic [4:0] wcnt;
  logic half_ok;
  logic ld_ok;
  logic fr_ok;
  logic tog;
  logic ld_fall;
  logic ld_rise;
  logic fr_fall;

  // edges of device-driven pins; a pin only just enabled has no edge
  assign tog = dev_oe[TX_BIT_TIMING] && oe_q[TX_BIT_TIMING] && dev_o[TX_BIT_TIMING] != o_q[TX_BIT_TIMING];
  assign ld_fall = dev_oe[TX_WORD_LOAD] && oe_q[TX_WORD_LOAD] && o_q[TX_WORD_LOAD] && !dev_o[TX_WORD_LOAD];
  assign ld_rise = dev_oe[TX_WORD_LOAD] && oe_q[TX_WORD_LOAD] && !o_q[TX_WORD_LOAD] && dev_o[TX_WORD_LOAD];
  assign fr_fall = dev_oe[FRAME_MARKER_LINE] && oe_q[FRAME_MARKER_LINE] && o_q[FRAME_MARKER_LINE]
                   && !dev_o[FRAME_MARKER_LINE];

  // drive values and enables one cycle back
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      {o_q, oe_q} <= '0;
    else
      {o_q, oe_q} <= {dev_o, dev_oe};

  // cycles since the active bit timing last toggled
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      {half_ok, half_cnt} <= '0;
    else if (!dev_oe[TX_BIT_TIMING])
      {half_ok, half_cnt} <= '0;
    else if (tog)
      {half_ok, half_cnt} <= {1'b1, 8'h01};
    else
      half_cnt <= half_cnt + 8'h01;

  // length of the active word-load low pulse
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      {ld_ok, ld_cnt} <= '0;
    else if (!dev_oe[TX_WORD_LOAD])
      {ld_ok, ld_cnt} <= '0;
    else if (ld_fall)
      {ld_ok, ld_cnt} <= {1'b1, 8'h01};
    else if (!dev_o[TX_WORD_LOAD])
      ld_cnt <= ld_cnt + 8'h01;

  // words per frame; the frame word itself counts as the first
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      {fr_ok, wcnt} <= '0;
    else if (!dev_oe[FRAME_MARKER_LINE])
      {fr_ok, wcnt} <= '0;
    else if (fr_fall)
      {fr_ok, wcnt} <= {1'b1, 5'h01};
    else if (ld_fall)
      wcnt <= wcnt + 5'h01;

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  // start of a word and of a frame as the device drives them
  sequence load_start;
    ld_fall;
  endsequence
  sequence frame_start;
    fr_fall;
  endsequence

  reset_float_a: assert property ($rose(rst_n) |-> dev_oe == '0)
    else $error("pin driven at reset release");
  tx_gate_a: assert property (level[TX_SLOT_ENABLE_N] [*6] |-> !dev_oe[SERIAL_TX_LINE])
    else $error("tx line driven while enable high");
  addr_gate_a: assert property (level[TX_SLOT_ENABLE_N] [*6] |-> !dev_oe[SERIAL_ADDR_LINE])
    else $error("address line driven while enable high");
  addr_follows_a: assert property (dev_oe[SERIAL_ADDR_LINE] == dev_oe[SERIAL_TX_LINE])
    else $error("address and tx line enables differ");
  bit_edge_a: assert property (dev_oe[SERIAL_TX_LINE] && oe_q[SERIAL_TX_LINE] && oe_q[TX_BIT_TIMING]
    && dev_o[SERIAL_TX_LINE] != o_q[SERIAL_TX_LINE] |-> tog && dev_o[TX_BIT_TIMING])
    else $error("tx line changed off a timing rise");
  half_bit_a: assert property (tog && half_ok |-> half_cnt == HALF_CYC)
    else $error("active half bit has wrong length");
  load_width_a: assert property (ld_rise && ld_ok |-> ld_cnt == 2 * HALF_CYC)
    else $error("word load low for wrong length");
  load_on_bit_a: assert property (load_start ##0 oe_q[TX_BIT_TIMING] |-> tog && dev_o[TX_BIT_TIMING])
    else $error("word load fell off a timing rise");
  frame_rate_a: assert property (frame_start ##0 fr_ok |-> wcnt == 5'h08 || wcnt == 5'h10)
    else $error("frame period not 8 or 16 words");
  frame_word_a: assert property (frame_start |-> load_start)
    else $error("frame fall without word load fall");
  enable_own_a: assert property (peer_oe[TX_SLOT_ENABLE_N] |-> !dev_oe[TX_SLOT_ENABLE_N])
    else $error("both ends drive the slot enable");
  frame_own_a: assert property (peer_oe[FRAME_MARKER_LINE] |->
    !peer_o[FRAME_MARKER_LINE] && !dev_oe[FRAME_MARKER_LINE])
    else $error("frame line contention or not held low");
endmodule

// ==== verif/test_serial_port_tdm.sv ====
// bench: device and peer joined by the link, device driven through its register port
// assumes HALF_CYC of 8 (64 ns bit), so one word takes 256 clk cycles
`timescale 1ns/1ps
module test_serial_port_tdm;
  import sio_pkg::*;
  // shorter half bits leave no margin for the two-flop sampling on both ends
  localparam int HC = HALF_BIT_CYC;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [WORD_W-1:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [WORD_W-1:0] rdata;
  logic irq;
  logic [3:0] pdrv = 4'h0;
  logic pmsb = 1'b0;
  logic member = 1'b0;
  logic en_dev = 1'b1;
  logic [WORD_W-1:0] send_word = 16'h0000;
  logic send_load = 1'b0;
  logic [WORD_W-1:0] recv_word;
  logic recv_valid;
  logic [WORD_W-1:0] v;
  logic [4:0] modes [4] = '{5'h1E, 5'h1F, 5'h00, 5'h01};
  int miscompares = 0;
  int n_compared = 0;
  wire [NPIN-1:0] lv;
  wire [NPIN-1:0] doe;

  sio_link_if u_sio_link_if ();
  assign lv = u_sio_link_if.level;
  assign doe = u_sio_link_if.dev_oe;

  sio_device #(.HALF_CYC(HC)) u_sio_device (.clk(clk), .rst_n(rst_n), .link(u_sio_link_if.device),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq));
  sio_peer #(.HALF_CYC(HC)) u_sio_peer (.clk(clk), .rst_n(rst_n), .link(u_sio_link_if.peer),
    .drive_rx_timing(pdrv[0]), .drive_rx_load(pdrv[1]), .drive_tx_timing(pdrv[2]), .drive_tx_load(pdrv[3]),
    .msb_first(pmsb), .tdm_member(member), .enable_device(en_dev), .send_word(send_word),
    .send_load(send_load), .recv_word(recv_word), .recv_valid(recv_valid));
  sio_monitor #(.HALF_CYC(HC)) u_sio_monitor (.clk(clk), .rst_n(rst_n), .dev_o(u_sio_link_if.dev_o),
    .dev_oe(u_sio_link_if.dev_oe), .peer_o(u_sio_link_if.peer_o), .peer_oe(u_sio_link_if.peer_oe),
    .level(u_sio_link_if.level));

  // 250 MHz clock
  initial
  begin
    forever #2 clk = ~clk;
  end

  // counts, verdict and end of run
  task automatic summarize();
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      miscompares++;
    end
  endtask

  // register port cycles; read data is taken in the cycle after the strobe
  task automatic wr_reg(input logic [2:0] a, input logic [15:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    // idle edge so a following write never sets the strobe in the same step
    @(posedge clk);
  endtask

  task automatic rd_reg(input logic [2:0] a, output logic [15:0] d);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    d = rdata;
  endtask

  // bounded polling; running out ends the run
  task automatic poll(input logic [2:0] a, input logic [15:0] m);
    logic [15:0] r;
    for (int i = 0; i < 200; i++)
    begin
      rd_reg(a, r);
      if ((r & m) != 16'h0000)
        return;
    end
    miscompares++;
    summarize();
  endtask

  task automatic get_word(output logic [15:0] w);
    for (int i = 0; i < 1000; i++)
    begin
      @(posedge clk);
      if (recv_valid === 1'b1)
      begin
        w = recv_word;
        return;
      end
    end
    miscompares++;
    summarize();
  endtask

  task automatic check_reset();
    logic [2:0] regs [6] = '{A_CTRL, A_TDM, A_STATUS, A_INT_ST, A_INT_MASK, 3'h7};
    logic [15:0] r;
    foreach (regs[i])
    begin
      rd_reg(regs[i], r);
      chk(r, (regs[i] == A_STATUS) ? 16'h0002 : 16'h0000);
    end
  endtask

  // one word each way; stale words around a mode change are skipped, up to two
  task automatic xfer(input logic [4:0] c, input logic [15:0] tw, input logic [15:0] pw);
    logic [15:0] r;
    logic hit;
    pdrv <= {4{~c[1]}};
    pmsb <= c[0];
    wr_reg(A_CTRL, {11'h000, c});
    // write just after a load, so no load can set tx empty again before the check
    wr_reg(A_INT_ST, 16'h0002);
    poll(A_INT_ST, 16'h0002);
    wr_reg(A_DATA, tw);
    rd_reg(A_STATUS, r);
    chk(r & 16'h0002, 16'h0000);
    hit = 1'b0;
    for (int k = 0; k < 3; k++)
    begin
      get_word(r);
      hit |= (r === tw);
    end
    chk({15'h0000, hit}, 16'h0001);
    rd_reg(A_STATUS, r);
    chk(r & 16'h0002, 16'h0002);
    send_word <= pw;
    send_load <= 1'b1;
    @(posedge clk);
    send_load <= 1'b0;
    hit = 1'b0;
    for (int k = 0; k < 3; k++)
    begin
      wr_reg(A_INT_ST, 16'h0001);
      poll(A_INT_ST, 16'h0001);
      rd_reg(A_STATUS, r);
      chk(r & 16'h0001, 16'h0001);
      rd_reg(A_DATA, r);
      hit |= (r === pw);
    end
    chk({15'h0000, hit}, 16'h0001);
    rd_reg(A_STATUS, r);
    chk(r & 16'h0001, 16'h0000);
  endtask

  // words between frame falls, and whether the device took its slot
  task automatic frame_gap(input logic [15:0] exp);
    logic [15:0] n;
    logic seen;
    logic pl;
    logic pf;
    int f;
    n = 16'h0000;
    seen = 1'b0;
    pl = 1'b1;
    pf = 1'b1;
    f = 0;
    for (int i = 0; i < 13000 && f < 3; i++)
    begin
      @(posedge clk);
      if (pl && !lv[TX_WORD_LOAD])
        n++;
      if (pf && !lv[FRAME_MARKER_LINE])
      begin
        if (f > 0)
          chk(n, exp);
        n = 16'h0000;
        f++;
      end
      seen |= doe[TX_SLOT_ENABLE_N] && !lv[TX_SLOT_ENABLE_N];
      pl = lv[TX_WORD_LOAD];
      pf = lv[FRAME_MARKER_LINE];
    end
    chk({15'h0000, seen}, 16'h0001);
    if (f < 3)
      miscompares++;
  endtask

  // main sequence
  initial
  begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    wr_reg(3'h7, 16'hFFFF);
    check_reset();
    wr_reg(A_ADDR_TX, 16'hC3A5);
    rd_reg(A_ADDR_TX, v);
    chk(v, 16'hC3A5);
    foreach (modes[i])
      xfer(modes[i], 16'h1234 + 16'(i), 16'h5A0F);
    wr_reg(A_INT_MASK, 16'h0000);
    // start from a fresh load so the later clear is not refilled at once
    wr_reg(A_INT_ST, 16'h0002);
    poll(A_INT_ST, 16'h0002);
    repeat (2) @(posedge clk);
    chk({15'h0000, irq}, 16'h0000);
    wr_reg(A_INT_MASK, 16'h0002);
    repeat (2) @(posedge clk);
    chk({15'h0000, irq}, 16'h0001);
    wr_reg(A_INT_ST, 16'h0002);
    rd_reg(A_INT_ST, v);
    chk(v & 16'h0002, 16'h0000);
    en_dev <= 1'b0;
    repeat (8) @(posedge clk);
    chk({15'h0000, doe[SERIAL_TX_LINE]}, 16'h0000);
    chk({15'h0000, doe[SERIAL_ADDR_LINE]}, 16'h0000);
    en_dev <= 1'b1;
    repeat (8) @(posedge clk);
    chk({15'h0000, doe[SERIAL_ADDR_LINE]}, 16'h0001);
    pdrv <= 4'h0;
    member <= 1'b1;
    wr_reg(A_CTRL, 16'h001E);
    wr_reg(A_TDM, 16'h0003);
    frame_gap(16'h0008);
    wr_reg(A_TDM, 16'h0007);
    frame_gap(16'h0010);
    wr_reg(A_TDM, 16'h0001);
    repeat (8) @(posedge clk);
    chk({15'h0000, doe[FRAME_MARKER_LINE]}, 16'h0000);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    check_reset();
    summarize();
  end
endmodule
